//--- hw/exc_pkg.sv
// Purpose: shared constants for the exception priority and entry unit
// Assumes: 32-bit addresses, six pipeline stages, word-aligned register port
// Notes: exception indices double as the cause code; lower index wins
package exc_pkg;
  localparam int STAGES = 6;
  localparam int NEXC = 27;

  // exception indices in falling priority
  localparam logic [4:0] E_COLD = 5'h00;
  localparam logic [4:0] E_SOFT = 5'h01;
  localparam logic [4:0] E_DSS = 5'h02;
  localparam logic [4:0] E_DEBUG_IRQ_EVENT = 5'h03;
  localparam logic [4:0] E_NMI = 5'h04;
  localparam logic [4:0] E_MCHK = 5'h05;
  localparam logic [4:0] E_INT = 5'h06;
  localparam logic [4:0] E_DIB = 5'h07;
  localparam logic [4:0] E_FADR = 5'h08;
  localparam logic [4:0] E_FTLB = 5'h09;
  localparam logic [4:0] E_XI = 5'h0a;
  localparam logic [4:0] E_IECC = 5'h0b;
  localparam logic [4:0] E_IBE = 5'h0c;
  localparam logic [4:0] E_CPU = 5'h0d;
  localparam logic [4:0] E_RI = 5'h0e;
  localparam logic [4:0] E_DBRK = 5'h0f;
  localparam logic [4:0] E_LADR = 5'h10;
  localparam logic [4:0] E_SADR = 5'h11;
  localparam logic [4:0] E_LTLB = 5'h12;
  localparam logic [4:0] E_STLB = 5'h13;
  localparam logic [4:0] E_RDI = 5'h14;
  localparam logic [4:0] E_MOD = 5'h15;
  localparam logic [4:0] E_DPAR = 5'h16;
  localparam logic [4:0] E_DECC = 5'h17;
  localparam logic [4:0] E_DBE = 5'h18;
  localparam logic [4:0] E_DLDC = 5'h19;
  localparam logic [4:0] E_COMPLEX_BREAKPOINT = 5'h1a;

  // register byte offsets
  localparam logic [7:0] A_STATUS = 8'h00;
  localparam logic [7:0] A_CAUSE = 8'h04;
  localparam logic [7:0] A_EPC = 8'h08;
  localparam logic [7:0] A_ERRPC = 8'h0c;
  localparam logic [7:0] A_DBGPC = 8'h10;
  localparam logic [7:0] A_DBGCTL = 8'h14;
  localparam logic [7:0] A_EBASE = 8'h18;

  // field positions
  localparam int S_IE = 0;
  localparam int S_EXL = 1;
  localparam int S_ERL = 2;
  localparam int S_UM = 4;
  localparam int S_IM_LO = 8;
  localparam int C_BD = 31;
  localparam int C_IV = 23;
  localparam int C_IP_LO = 8;
  localparam int C_CODE_LO = 2;
  localparam int D_BRK = 0;
  localparam int D_SSTEP = 1;
  localparam int D_MODE = 2;

  // reset values and vectors
  localparam logic STATUS_ERL_RST = 1'b1;
  localparam logic [31:0] EBASE_RST = 32'h0000_0000;
  localparam logic [31:0] RESET_VECTOR = 32'h0000_1000;
  localparam logic [31:0] DEBUG_VECTOR = 32'h0000_2000;
  localparam logic [31:0] GEN_OFFSET = 32'h0000_0180;
  localparam logic [31:0] IRQ_OFFSET = 32'h0000_0200;
  localparam logic [31:0] FETCH_ALIGN_MASK = 32'h0000_0001;
endpackage

//--- hw/exc_prio_pick.sv
// Purpose: pick the lowest set index of the pending exception vector
// Assumes: index 0 is the highest priority
// Notes: purely combinational
module exc_prio_pick (
  input wire logic [exc_pkg::NEXC-1:0] req_in,
  output logic any_out,
  output logic [4:0] idx_out
);
  always_comb begin
    any_out = |req_in;
    idx_out = 5'h00;
    // scan downward so the last hit is the lowest index
    for (int i = exc_pkg::NEXC - 1; i >= 0; i--) begin
      if (req_in[i]) begin
        idx_out = 5'(i);
      end
    end
  end
endmodule

//--- hw/exc_entry.sv
// Purpose: exception detection, prioritisation and entry for a six-stage pipeline
// Assumes: stages advance together on pipe_advance_in; decision made as align moves into writeback
// Notes: only compatibility dispatch; registers reached over a plain strobe port
//
// Local design decisions: the address map and the address-and-strobe port.
module exc_entry (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  input wire logic power_on_reset_n_in,
  input wire logic soft_reset_n_in,
  input wire logic debug_irq_input_in,
  input wire logic nmi_in,
  input wire logic [5:0] hw_irq_in,
  input wire logic timer_irq_in,
  input wire logic pipe_advance_in,
  input wire logic [5:0] stall_req_in,
  input wire logic fetch_valid_in,
  input wire logic [31:0] fetch_pc_in,
  input wire logic fetch_in_slot_in,
  input wire logic [31:0] fetch_branch_pc_in,
  input wire logic debug_instr_break_in,
  input wire logic fetch_mapped_in,
  input wire logic fetch_tlb_hit_in,
  input wire logic fetch_tlb_valid_in,
  input wire logic fetch_execute_inhibit_bit_in,
  input wire logic fetch_ecc_err_in,
  input wire logic fetch_bus_error_in,
  input wire logic cop_unusable_in,
  input wire logic dsp_disabled_trap_in,
  input wire logic reserved_instr_in,
  input wire logic tlb_write_conflict_in,
  input wire logic data_break_in,
  input wire logic data_load_in,
  input wire logic data_store_in,
  input wire logic [31:0] data_addr_in,
  input wire logic data_misaligned_in,
  input wire logic data_mapped_in,
  input wire logic data_tlb_hit_in,
  input wire logic data_tlb_valid_in,
  input wire logic data_read_inhibit_bit_in,
  input wire logic data_writable_in,
  input wire logic dmem_parity_err_in,
  input wire logic dmem_ecc_err_in,
  input wire logic data_bus_error_in,
  input wire logic load_compare_break_in,
  input wire logic complex_breakpoint_in,
  input wire logic eret_in,
  input wire logic deret_in,
  output logic redirect_out,
  output logic [31:0] redirect_pc_out,
  output logic flush_out,
  output logic retire_out,
  output logic stall_out,
  output logic kernel_mode_out,
  output logic error_level_bit_out,
  output logic debug_mode_out,
  output logic [5:0] stage_valid_out
);
  localparam int N = exc_pkg::NEXC;

  function automatic logic addr_err(input logic [31:0] addr, input logic misaligned, input logic user);
    addr_err = misaligned | (user & addr[31]);
  endfunction

  // per-stage record carried alongside the pipeline
  logic rec_valid_q [exc_pkg::STAGES];
  logic [31:0] rec_pc_q [exc_pkg::STAGES];
  logic [31:0] rec_bpc_q [exc_pkg::STAGES];
  logic rec_slot_q [exc_pkg::STAGES];
  logic [N-1:0] rec_exc_q [exc_pkg::STAGES];

  logic ie_q, exl_q, erl_q, um_q, iv_q, bd_q, dbrk_q, sstep_q, dbg_q;
  logic ie_d, exl_d, erl_d, um_d, iv_d, bd_d, dbrk_d, sstep_d, dbg_d;
  logic [7:0] im_q, im_d;
  logic [1:0] sw_ip_q, sw_ip_d;
  logic [5:0] hw_ip_q;
  logic [4:0] code_q, code_d;
  logic [31:0] epc_q, epc_d, errpc_q, errpc_d, dbgpc_q, dbgpc_d, ebase_q, ebase_d;
  logic nmi_prev_q, nmi_pend_q;
  logic redirect_q, flush_q, retire_q, stall_q, kernel_q;
  logic [31:0] redirect_pc_q, rdata_q;

  logic [N-1:0] fetch_exc, exec_exc, mem_exc, late_exc, cand;
  logic take, slot_ok, irq_req, err_cls, dbg_cls, user_now, dtlb_ok;
  logic [4:0] pick;
  logic [31:0] vec, restart, rd_mux;
  logic [7:0] ip_all;
  logic [N-1:0] dbg_bits;

  assign user_now = ~kernel_q;
  assign slot_ok = pipe_advance_in & rec_valid_q[4];
  assign dtlb_ok = data_mapped_in & data_tlb_hit_in & data_tlb_valid_in;

  // fetch-side detection, recorded with the fetched instruction
  always_comb begin
    fetch_exc = '0;
    fetch_exc[exc_pkg::E_DIB] = debug_instr_break_in;
    fetch_exc[exc_pkg::E_FADR] = addr_err(fetch_pc_in, |(fetch_pc_in & exc_pkg::FETCH_ALIGN_MASK),
                                          user_now);
    fetch_exc[exc_pkg::E_FTLB] = fetch_mapped_in & (~fetch_tlb_hit_in | ~fetch_tlb_valid_in);
    fetch_exc[exc_pkg::E_XI] = fetch_mapped_in & fetch_tlb_hit_in & fetch_tlb_valid_in &
                               fetch_execute_inhibit_bit_in;
    fetch_exc[exc_pkg::E_IECC] = fetch_ecc_err_in;
    fetch_exc[exc_pkg::E_IBE] = fetch_bus_error_in;
  end

  // execute stage: dsp-disabled shares the coprocessor-unusable slot
  always_comb begin
    exec_exc = '0;
    exec_exc[exc_pkg::E_CPU] = cop_unusable_in | dsp_disabled_trap_in;
    exec_exc[exc_pkg::E_RI] = reserved_instr_in;
  end

  // memory stage
  always_comb begin
    mem_exc = '0;
    mem_exc[exc_pkg::E_MCHK] = tlb_write_conflict_in;
    mem_exc[exc_pkg::E_DBRK] = data_break_in;
    mem_exc[exc_pkg::E_LADR] = data_load_in & addr_err(data_addr_in, data_misaligned_in, user_now);
    mem_exc[exc_pkg::E_SADR] = data_store_in & addr_err(data_addr_in, data_misaligned_in, user_now);
    mem_exc[exc_pkg::E_LTLB] = data_load_in & data_mapped_in & ~dtlb_ok;
    mem_exc[exc_pkg::E_STLB] = data_store_in & data_mapped_in & ~dtlb_ok;
    mem_exc[exc_pkg::E_RDI] = data_load_in & dtlb_ok & data_read_inhibit_bit_in;
    mem_exc[exc_pkg::E_MOD] = data_store_in & dtlb_ok & ~data_writable_in;
  end

  // late errors may belong to an older access; the instruction in align takes them
  always_comb begin
    late_exc = '0;
    late_exc[exc_pkg::E_DPAR] = dmem_parity_err_in;
    late_exc[exc_pkg::E_DECC] = dmem_ecc_err_in;
    late_exc[exc_pkg::E_DBE] = data_bus_error_in;
    late_exc[exc_pkg::E_DLDC] = load_compare_break_in;
    late_exc[exc_pkg::E_COMPLEX_BREAKPOINT] = complex_breakpoint_in;
  end

  assign ip_all = {hw_ip_q, sw_ip_q};
  assign irq_req = |(ip_all & im_q) & ie_q & ~exl_q & ~erl_q & ~dbg_q;

  // debug-class causes are not taken again while already in debug mode
  always_comb begin
    dbg_bits = '0;
    dbg_bits[exc_pkg::E_DIB] = 1'b1;
    dbg_bits[exc_pkg::E_DBRK] = 1'b1;
    dbg_bits[exc_pkg::E_DLDC] = 1'b1;
    dbg_bits[exc_pkg::E_COMPLEX_BREAKPOINT] = 1'b1;
  end

  // index order fixes the ranking of every cause
  always_comb begin
    cand = (rec_exc_q[4] | late_exc) & {N{slot_ok}};
    cand = cand & ~(dbg_bits & {N{dbg_q}});
    cand[exc_pkg::E_COLD] = ~power_on_reset_n_in;
    cand[exc_pkg::E_SOFT] = ~soft_reset_n_in;
    cand[exc_pkg::E_DSS] = sstep_q & ~dbg_q & slot_ok;
    cand[exc_pkg::E_DEBUG_IRQ_EVENT] = (debug_irq_input_in | dbrk_q) & ~dbg_q & slot_ok;
    cand[exc_pkg::E_NMI] = nmi_pend_q & slot_ok;
    cand[exc_pkg::E_INT] = irq_req & slot_ok;
  end

  exc_prio_pick u_pick (
    .req_in(cand),
    .any_out(take),
    .idx_out(pick)
  );

  assign err_cls = (pick == exc_pkg::E_COLD) | (pick == exc_pkg::E_SOFT) | (pick == exc_pkg::E_NMI);
  assign dbg_cls = (pick == exc_pkg::E_DSS) | (pick == exc_pkg::E_DEBUG_IRQ_EVENT) | dbg_bits[pick];
  assign restart = rec_slot_q[4] ? rec_bpc_q[4] : rec_pc_q[4];
  assign vec = err_cls ? exc_pkg::RESET_VECTOR :
               dbg_cls ? exc_pkg::DEBUG_VECTOR :
               ((pick == exc_pkg::E_INT) && iv_q) ? ebase_q + exc_pkg::IRQ_OFFSET :
               ebase_q + exc_pkg::GEN_OFFSET;

  // register state: software first, then returns, then exception entry wins
  always_comb begin
    ie_d = ie_q;
    exl_d = exl_q;
    erl_d = erl_q;
    um_d = um_q;
    im_d = im_q;
    iv_d = iv_q;
    bd_d = bd_q;
    code_d = code_q;
    sw_ip_d = sw_ip_q;
    epc_d = epc_q;
    errpc_d = errpc_q;
    dbgpc_d = dbgpc_q;
    ebase_d = ebase_q;
    dbrk_d = dbrk_q;
    sstep_d = sstep_q;
    dbg_d = dbg_q;
    if (reg_wr_in) begin
      if (reg_addr_in == exc_pkg::A_STATUS) begin
        ie_d = reg_wdata_in[exc_pkg::S_IE];
        exl_d = reg_wdata_in[exc_pkg::S_EXL];
        erl_d = reg_wdata_in[exc_pkg::S_ERL];
        um_d = reg_wdata_in[exc_pkg::S_UM];
        im_d = reg_wdata_in[exc_pkg::S_IM_LO +: 8];
      end else if (reg_addr_in == exc_pkg::A_CAUSE) begin
        iv_d = reg_wdata_in[exc_pkg::C_IV];
        sw_ip_d = reg_wdata_in[exc_pkg::C_IP_LO +: 2];
      end else if (reg_addr_in == exc_pkg::A_EPC) begin
        epc_d = reg_wdata_in;
      end else if (reg_addr_in == exc_pkg::A_ERRPC) begin
        errpc_d = reg_wdata_in;
      end else if (reg_addr_in == exc_pkg::A_DBGPC) begin
        dbgpc_d = reg_wdata_in;
      end else if (reg_addr_in == exc_pkg::A_DBGCTL) begin
        dbrk_d = reg_wdata_in[exc_pkg::D_BRK];
        sstep_d = reg_wdata_in[exc_pkg::D_SSTEP];
      end else if (reg_addr_in == exc_pkg::A_EBASE) begin
        ebase_d = reg_wdata_in;
      end
    end
    if (eret_in) begin
      if (erl_q) begin
        erl_d = 1'b0;
      end else begin
        exl_d = 1'b0;
      end
    end
    if (deret_in) begin
      dbg_d = 1'b0;
    end
    if (take) begin
      if (dbg_cls) begin
        dbg_d = 1'b1;
        dbgpc_d = restart;
        if (pick == exc_pkg::E_DEBUG_IRQ_EVENT) begin
          dbrk_d = 1'b0;
        end
      end else if (err_cls) begin
        erl_d = 1'b1;
        errpc_d = restart;
        if (pick == exc_pkg::E_COLD) begin
          iv_d = 1'b0;
          um_d = 1'b0;
        end
      end else begin
        // nested entry keeps the first restart address
        if (!exl_q) begin
          epc_d = restart;
          bd_d = rec_slot_q[4];
        end
        exl_d = 1'b1;
        code_d = pick;
      end
    end
  end

  // read data stand only in the cycle after the strobe; unmapped offsets read zero
  assign rd_mux = (reg_addr_in == exc_pkg::A_STATUS) ?
                    (32'(im_q) << exc_pkg::S_IM_LO) | (32'(um_q) << exc_pkg::S_UM) |
                    (32'(erl_q) << exc_pkg::S_ERL) | (32'(exl_q) << exc_pkg::S_EXL) | 32'(ie_q) :
                  (reg_addr_in == exc_pkg::A_CAUSE) ?
                    (32'(bd_q) << exc_pkg::C_BD) | (32'(iv_q) << exc_pkg::C_IV) |
                    (32'(ip_all) << exc_pkg::C_IP_LO) | (32'(code_q) << exc_pkg::C_CODE_LO) :
                  (reg_addr_in == exc_pkg::A_EPC) ? epc_q :
                  (reg_addr_in == exc_pkg::A_ERRPC) ? errpc_q :
                  (reg_addr_in == exc_pkg::A_DBGPC) ? dbgpc_q :
                  (reg_addr_in == exc_pkg::A_DBGCTL) ?
                    (32'(dbg_q) << exc_pkg::D_MODE) | (32'(sstep_q) << exc_pkg::D_SSTEP) | 32'(dbrk_q) :
                  (reg_addr_in == exc_pkg::A_EBASE) ? ebase_q : 32'h0000_0000;

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      {ie_q, exl_q, um_q, iv_q, bd_q, dbrk_q, sstep_q, dbg_q} <= '0;
      erl_q <= exc_pkg::STATUS_ERL_RST;
      im_q <= '0;
      sw_ip_q <= '0;
      hw_ip_q <= '0;
      code_q <= '0;
      {epc_q, errpc_q, dbgpc_q} <= '0;
      ebase_q <= exc_pkg::EBASE_RST;
      rdata_q <= '0;
    end else begin
      {ie_q, exl_q, erl_q, um_q, iv_q, bd_q} <= {ie_d, exl_d, erl_d, um_d, iv_d, bd_d};
      {dbrk_q, sstep_q, dbg_q} <= {dbrk_d, sstep_d, dbg_d};
      im_q <= im_d;
      sw_ip_q <= sw_ip_d;
      hw_ip_q <= {hw_irq_in[5] | timer_irq_in, hw_irq_in[4:0]};
      code_q <= code_d;
      {epc_q, errpc_q, dbgpc_q, ebase_q} <= {epc_d, errpc_d, dbgpc_d, ebase_d};
      rdata_q <= reg_rd_in ? rd_mux : 32'h0000_0000;
    end
  end

  // edge-triggered nmi; a new edge in the taking cycle re-arms it
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      nmi_prev_q <= 1'b0;
      nmi_pend_q <= 1'b0;
    end else begin
      nmi_prev_q <= nmi_in;
      nmi_pend_q <= (nmi_in & ~nmi_prev_q) | (nmi_pend_q & ~(take && pick == exc_pkg::E_NMI));
    end
  end

  // record pipe: a commit clears every stage, killing younger flagged work
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in || take) begin
      for (int s = 0; s < exc_pkg::STAGES; s++) begin
        rec_valid_q[s] <= 1'b0;
        rec_exc_q[s] <= '0;
      end
    end else if (pipe_advance_in) begin
      rec_valid_q[0] <= fetch_valid_in & ~flush_q;
      rec_exc_q[0] <= fetch_exc;
      for (int s = 1; s < exc_pkg::STAGES; s++) begin
        rec_valid_q[s] <= rec_valid_q[s-1];
      end
      rec_exc_q[1] <= rec_exc_q[0];
      rec_exc_q[2] <= rec_exc_q[1];
      rec_exc_q[3] <= rec_exc_q[2] | exec_exc;
      rec_exc_q[4] <= rec_exc_q[3] | mem_exc;
      rec_exc_q[5] <= '0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (pipe_advance_in) begin
      rec_pc_q[0] <= fetch_pc_in;
      rec_bpc_q[0] <= fetch_branch_pc_in;
      rec_slot_q[0] <= fetch_in_slot_in;
      for (int s = 1; s < exc_pkg::STAGES; s++) begin
        rec_pc_q[s] <= rec_pc_q[s-1];
        rec_bpc_q[s] <= rec_bpc_q[s-1];
        rec_slot_q[s] <= rec_slot_q[s-1];
      end
    end
  end

  // one decision per advance, but cold and soft reset are taken in any cycle; redirect and flush leave together
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      {redirect_q, flush_q, retire_q, stall_q, kernel_q} <= '0;
      redirect_pc_q <= '0;
    end else begin
      redirect_q <= take;
      flush_q <= take;
      redirect_pc_q <= take ? vec : redirect_pc_q;
      retire_q <= slot_ok & ~take;
      stall_q <= |(stall_req_in & {rec_valid_q[5], rec_valid_q[4], rec_valid_q[3],
                                   rec_valid_q[2], rec_valid_q[1], rec_valid_q[0]}) & ~take;
      kernel_q <= ~um_d | exl_d | erl_d | dbg_d;
    end
  end

  assign reg_rdata_out = rdata_q;
  assign redirect_out = redirect_q;
  assign redirect_pc_out = redirect_pc_q;
  assign flush_out = flush_q;
  assign retire_out = retire_q;
  assign stall_out = stall_q;
  assign kernel_mode_out = kernel_q;
  assign error_level_bit_out = erl_q;
  assign debug_mode_out = dbg_q;
  assign stage_valid_out = {rec_valid_q[5], rec_valid_q[4], rec_valid_q[3],
                            rec_valid_q[2], rec_valid_q[1], rec_valid_q[0]};
endmodule

//--- verif/exc_entry_asserts.sv
// Purpose: port-level checks for exc_entry
// Assumes: one clock, synchronous active-high reset
// Notes: vectors are taken from exc_pkg
module exc_entry_asserts (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic power_on_reset_n_in,
  input wire logic soft_reset_n_in,
  input wire logic [5:0] stall_req_in,
  input wire logic pipe_advance_in,
  input wire logic redirect_out,
  input wire logic [31:0] redirect_pc_out,
  input wire logic flush_out,
  input wire logic retire_out,
  input wire logic stall_out,
  input wire logic kernel_mode_out,
  input wire logic error_level_bit_out,
  input wire logic debug_mode_out,
  input wire logic [5:0] stage_valid_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  sequence s_take;
    redirect_out && flush_out;
  endsequence
  sequence s_rst_vec;
    s_take ##0 (redirect_pc_out == exc_pkg::RESET_VECTOR) ##0 error_level_bit_out;
  endsequence
  a_flush_pair: assert property ((redirect_out || flush_out) |->
    s_take ##0 stage_valid_out == 6'h00)
    else $error("flush and redirect apart");
  a_one_commit: assert property (s_take ##0 (power_on_reset_n_in && soft_reset_n_in) |=>
    !redirect_out)
    else $error("second commit");
  a_cold_entry: assert property (!power_on_reset_n_in |=> s_rst_vec)
    else $error("cold reset not taken");
  a_soft_entry: assert property (power_on_reset_n_in && !soft_reset_n_in |=> s_rst_vec)
    else $error("soft reset not taken");
  a_kernel_entry: assert property (s_take |-> kernel_mode_out)
    else $error("entry without kernel mode");
  a_debug_entry: assert property ($rose(debug_mode_out) |->
    s_take ##0 redirect_pc_out == exc_pkg::DEBUG_VECTOR)
    else $error("debug entry off vector");
  a_stall_gate: assert property (stall_out |-> $past(|(stall_req_in & stage_valid_out)))
    else $error("stall from dead stage");
  a_no_retire: assert property (flush_out |=> !retire_out)
    else $error("retire after flush");
  // a retire needs a live align entry that advanced and did not except
  a_retire_step: assert property (retire_out |->
    !redirect_out && $past(pipe_advance_in && stage_valid_out[4]))
    else $error("retire without advancing entry");
endmodule

bind exc_entry exc_entry_asserts u_chk (.*);

//--- verif/exc_pipe_model.sv
// Purpose: pipeline and fetch stream facing exc_entry
// Assumes: a stall holds every stage together
// Notes: slow_in adds random idle edges; fetch jumps to the vector on redirect
module exc_pipe_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic slow_in,
  input wire logic redirect_in,
  input wire logic [31:0] redirect_pc_in,
  input wire logic stall_in,
  output logic advance_out = 1'b0,
  output logic [5:0] stall_req_out = 6'h00,
  output logic [31:0] pc_out = 32'h0000_1000,
  output logic [31:0] branch_pc_out
);
  timeunit 1ns;
  timeprecision 1ps;
  assign branch_pc_out = pc_out - 32'h4;
  always @(posedge clk_in) begin
    stall_req_out <= 6'($urandom & $urandom & $urandom);
    advance_out <= !rst_in && !stall_in && !(slow_in && ($urandom % 2));
    if (rst_in)
      pc_out <= 32'h0000_1000;
    else if (redirect_in)
      pc_out <= redirect_pc_in;
    else if (advance_out)
      pc_out <= pc_out + 32'h4;
  end
endmodule

//--- verif/tb.sv
// Purpose: self-checking bench for exc_entry
// Assumes: exc_pipe_model keeps the pipe moving
// Notes: expected cause codes come from a stage-age and priority model
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 0, sys_rst_in = 1, reg_wr_in = 0, reg_rd_in = 0, power_on_reset_n_in = 1;
  logic soft_reset_n_in = 1, debug_irq_input_in = 0, nmi_in = 0, timer_irq_in = 0, fetch_in_slot_in = 0;
  logic eret_in = 0, deret_in = 0, slow = 0, fetch_valid_in = 1, debug_instr_break_in = 0;
  logic data_break_in = 0, load_compare_break_in = 0, complex_breakpoint_in = 0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0, data_addr_in = 32'h0, reg_rdata_out, fetch_pc_in, fetch_branch_pc_in;
  logic [31:0] redirect_pc_out;
  logic [5:0] hw_irq_in = 6'h00, stall_req_in, stage_valid_out;
  logic [15:0] f = 16'h0;
  logic pipe_advance_in, redirect_out, flush_out, retire_out, stall_out, kernel_mode_out;
  logic error_level_bit_out, debug_mode_out;
  wire fetch_mapped_in = f[0] | f[1], fetch_tlb_hit_in = f[1], fetch_tlb_valid_in = f[1];
  wire fetch_execute_inhibit_bit_in = f[1], fetch_ecc_err_in = f[2], fetch_bus_error_in = f[3];
  wire cop_unusable_in = f[4], reserved_instr_in = f[5], dsp_disabled_trap_in = f[6];
  wire data_load_in = f[7] | f[13], data_store_in = f[8], data_mapped_in = f[7] | f[8];
  wire data_tlb_hit_in = data_mapped_in, data_tlb_valid_in = data_mapped_in, data_read_inhibit_bit_in = f[7];
  wire data_writable_in = !f[8], dmem_parity_err_in = f[9], dmem_ecc_err_in = f[10];
  wire data_bus_error_in = f[11], tlb_write_conflict_in = f[12], data_misaligned_in = f[13];
  int miscompares = 0, tests_run = 0;
  int cd[14] = '{9, 10, 11, 12, 13, 14, 13, 20, 21, 22, 23, 24, 5, 16};
  int st[14] = '{0, 0, 0, 0, 2, 2, 2, 3, 3, 4, 4, 4, 3, 3};
  logic [15:0] q[$] = '{16'h000d, 16'h000a, 16'h000c, 16'h0008, 16'h0030, 16'h0040,
    16'h0080, 16'h0300, 16'h0c00, 16'h0808, 16'h1080, 16'h2000};
  always #12.5 core_clk_in = ~core_clk_in;
  exc_pipe_model u_pipe (.clk_in(core_clk_in), .rst_in(sys_rst_in), .slow_in(slow), .redirect_in(redirect_out),
    .redirect_pc_in(redirect_pc_out), .stall_in(stall_out), .advance_out(pipe_advance_in),
    .stall_req_out(stall_req_in), .pc_out(fetch_pc_in), .branch_pc_out(fetch_branch_pc_in));
  exc_entry u_dut (.*);
  // older stage wins first, then the lower index inside one stage
  function automatic int exp_code(input logic [15:0] m);
    int s = -1;
    int c = 99;
    for (int b = 0; b < 14; b++)
      if (m[b] && (st[b] > s || (st[b] == s && cd[b] < c))) begin
        s = st[b];
        c = cd[b];
      end
    return c;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1;
    @(posedge core_clk_in);
    reg_wr_in <= 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1;
    @(posedge core_clk_in);
    reg_rd_in <= 0;
    @(posedge core_clk_in);
    d = reg_rdata_out;
  endtask
  task automatic leave(input bit dbg);
    @(posedge core_clk_in);
    if (dbg)
      deret_in <= 1;
    else
      eret_in <= 1;
    @(posedge core_clk_in);
    deret_in <= 0;
    eret_in <= 0;
  endtask
  task automatic wait_take(input int n, output bit got);
    got = 0;
    for (int i = 0; i < n && !got; i++) begin
      @(posedge core_clk_in);
      got = redirect_out;
    end
  endtask
  // a wait that runs out is a mismatch and ends the run
  task automatic guard(input bit ok);
    if (!ok) begin
      miscompares++;
      end_sim;
    end
  endtask
  task automatic take(input logic [31:0] vec);
    bit got;
    wait_take(80, got);
    guard(got);
    chk(redirect_pc_out, vec);
  endtask
  initial begin
    logic [31:0] d, exception_return_pc;
    bit got, sl;
    int k;
    void'($urandom(32'h9154e937));
    repeat (3) @(posedge core_clk_in);
    sys_rst_in <= 0;
    @(posedge core_clk_in);
    chk(error_level_bit_out, 1'b1);
    rd(exc_pkg::A_CAUSE, d);
    chk(d[23], 1'b0);
    slow <= 1;
    // run in user mode, so kernel mode shows up only when an interrupt is taken
    for (int i = 0; i < 4; i++) begin
      k = (i == 2) ? 5 : $urandom % 5;
      wr(exc_pkg::A_CAUSE, {8'h00, 1'(i % 2), 23'h0});
      wr(exc_pkg::A_STATUS, (i == 3) ? 32'h11 : 32'h11 | (32'h100 << (k + 2)));
      if (i == 2)
        timer_irq_in <= 1;
      else
        hw_irq_in[k] <= 1'b1;
      wait_take(80, got);
      chk(got, i != 3);
      if (got)
        chk(redirect_pc_out, (i % 2) ? exc_pkg::IRQ_OFFSET : exc_pkg::GEN_OFFSET);
      chk(kernel_mode_out, got);
      hw_irq_in <= 6'h00;
      timer_irq_in <= 0;
      rd(exc_pkg::A_CAUSE, d);
      if (got)
        chk(d[6:2], exc_pkg::E_INT);
      leave(0);
    end
    slow <= 0;
    wr(exc_pkg::A_STATUS, 32'h0);
    foreach (q[j]) begin
      for (int i = 0; i < 60 && stage_valid_out !== 6'h3f; i++)
        @(posedge core_clk_in);
      chk(stage_valid_out, 6'h3f);
      guard(stage_valid_out === 6'h3f);
      @(posedge core_clk_in);
      f <= q[j];
      fetch_in_slot_in <= 1'($urandom);
      data_addr_in <= $urandom & 32'hffff_fffc;
      got = 0;
      for (int i = 0; i < 20 && !got; i++) begin
        @(posedge core_clk_in);
        got = pipe_advance_in;
      end
      guard(got);
      sl = fetch_in_slot_in;
      exception_return_pc = fetch_pc_in - (sl ? 32'h4 : 32'h0);
      f <= 16'h0;
      fetch_in_slot_in <= 0;
      take(exc_pkg::GEN_OFFSET);
      rd(exc_pkg::A_CAUSE, d);
      chk(d[6:2], exp_code(q[j]));
      if (q[j] < 16'h0010) begin
        chk(d[31], sl);
        rd(exc_pkg::A_EPC, d);
        chk(d, exception_return_pc);
      end
      leave(0);
    end
    nmi_in <= 1;
    take(exc_pkg::RESET_VECTOR);
    chk(error_level_bit_out, 1'b1);
    wait_take(40, got);
    chk(got, 1'b0);
    nmi_in <= 0;
    leave(0);
    // pin, break request, single step, then a late complex breakpoint
    for (int i = 0; i < 4; i++) begin
      if (i == 0)
        debug_irq_input_in <= 1;
      else if (i == 3)
        complex_breakpoint_in <= 1;
      else
        wr(exc_pkg::A_DBGCTL, {30'h0, 2'(i)});
      take(exc_pkg::DEBUG_VECTOR);
      chk(debug_mode_out, 1'b1);
      debug_irq_input_in <= 0;
      complex_breakpoint_in <= 0;
      // single step would fire again after the return unless cleared inside debug mode
      if (i == 2)
        wr(exc_pkg::A_DBGCTL, 32'h0);
      leave(1);
    end
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk_in);
      if (i == 0)
        power_on_reset_n_in <= 0;
      else
        soft_reset_n_in <= 0;
      @(posedge core_clk_in);
      power_on_reset_n_in <= 1;
      soft_reset_n_in <= 1;
      take(exc_pkg::RESET_VECTOR);
      chk(error_level_bit_out, 1'b1);
    end
    end_sim;
  end
endmodule
